// *** ppgt_pkg.sv ***
`default_nettype none
package ppgt_pkg;
  // Timer pair mode codes
  typedef enum logic [1:0] {
    PPGT_MODE_TIMER8 = 2'b00,
    PPGT_MODE_TIMER16 = 2'b01,
    PPGT_MODE_PULSE = 2'b10,
    PPGT_MODE_PWM = 2'b11
  } ppgt_mode_t;

  // Lower timer clock source codes
  localparam logic [1:0] PPGT_CLK_EXT = 2'h0;
  localparam logic [1:0] PPGT_CLK_FINE = 2'h1;
  localparam logic [1:0] PPGT_CLK_MID = 2'h2;
  localparam logic [1:0] PPGT_CLK_COARSE = 2'h3;

  // Pulse-width cycle codes
  localparam logic [1:0] PPGT_CYC_64 = 2'h1;
  localparam logic [1:0] PPGT_CYC_128 = 2'h2;
  localparam logic [1:0] PPGT_CYC_256 = 2'h3;

  // Flip-flop control field codes
  localparam logic [1:0] PPGT_FF_INVERT = 2'h0;
  localparam logic [1:0] PPGT_FF_SET = 2'h1;
  localparam logic [1:0] PPGT_FF_CLEAR = 2'h2;

  // Reset values
  localparam logic [7:0] PPGT_CNT_RST = 8'h00;
  localparam logic [7:0] PPGT_CMP_RST = 8'h00;
  localparam logic PPGT_FF_RST = 1'b0;
endpackage
`default_nettype wire

// *** ppgt_edge.sv ***
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser plus rising-edge pulse for a pin-sourced clock
module ppgt_edge (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic pin,
  output logic rise
);
  logic meta;
  logic sync;
  logic last;

  // Only the second stage and its delayed copy feed the detector
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      last <= sync;
    end
  end

  assign rise = sync & ~last;
endmodule
`default_nettype wire

// *** ppgt_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Programmable-pulse mode: lower timer alone makes adjustable square wave
// - Programmable-pulse: output toggles on match with either compare register
// - Pulse mode: buffered lower compare loads on upper compare match
// - Compare value 00h means 100h; matches on counter overflow
// - Output polarity follows written initial flip-flop state; 10 gives low
// - Pulse-width mode on lower timer only, 8-bit, drives output pin
// - Upper timer stays an independent 8-bit timer in pulse-width mode
// - Pulse-width: toggle on lower compare match and on 2^n overflow
// - Pulse-width: lower counter clears at the selected 2^n overflow
// - Pulse-width: buffered lower compare loads at each 2^n overflow
// - Clearing a run bit stops that timer and zeroes its counter
// - Mode 10 is programmable pulse, 11 pulse width; cycle 01/10/11
// - Lower clock select 00 external, 01/10/11 fine, mid, coarse taps; upper select 00 gives no clock
module ppgt_timer (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ext_clk_pin,
  input wire logic prescale_tap_fine,
  input wire logic prescale_tap_mid,
  input wire logic prescale_tap_coarse,
  input wire logic lower_run_bit,
  input wire logic upper_run_bit,
  input wire logic dbuf_enable,
  input wire ppgt_pkg::ppgt_mode_t mode_sel,
  input wire logic [1:0] pwm_cycle_select,
  input wire logic [1:0] lower_clk_select,
  input wire logic [1:0] upper_clk_select,
  input wire logic lower_cmp_wr,
  input wire logic upper_cmp_wr,
  input wire logic [7:0] cmp_wdata,
  input wire logic ff_ctrl_wr,
  input wire logic [1:0] ff_ctrl_op,
  input wire logic invert_enable,
  output logic timer_output_pin,
  output logic upper_match,
  output logic [7:0] lower_up_counter,
  output logic [7:0] upper_up_counter,
  output logic [7:0] lower_compare_reg,
  output logic [7:0] upper_compare_reg
);
  import ppgt_pkg::*;

  logic ext_rise;
  logic lower_tick;
  logic upper_tick;
  logic [7:0] lower_buffer;
  logic output_flip_flop;
  logic programmable_pulse_mode;
  logic pwm_mode;
  logic lo_match;
  logic hi_match;
  logic ovf_2n;
  logic clear_lower;
  logic ff_event;
  logic [7:0] lower_next;

  // Compare hit: 00h stands for 100h, so it fires on the wrap from ffh
  function automatic logic cmp_hit(input logic tick, input logic [7:0] cnt,
                                   input logic [7:0] cmp);
    logic hit;
    hit = 1'b0;
    if (tick) begin
      if (cmp == 8'h00) begin
        hit = (cnt == 8'hff);
      end else begin
        hit = (cnt + 8'h01 == cmp);
      end
    end
    return hit;
  endfunction

  ppgt_edge u_ext (
    .mclk(mclk),
    .rstn(rstn),
    .pin(ext_clk_pin),
    .rise(ext_rise)
  );

  // Lower clock source mux; taps are one-cycle enables from the prescaler
  always_comb begin
    unique case (lower_clk_select)
      PPGT_CLK_EXT: lower_tick = ext_rise;
      PPGT_CLK_FINE: lower_tick = prescale_tap_fine;
      PPGT_CLK_MID: lower_tick = prescale_tap_mid;
      PPGT_CLK_COARSE: lower_tick = prescale_tap_coarse;
    endcase
  end

  // Upper timer counts taps only; chaining off the lower match is not built
  always_comb begin
    unique case (upper_clk_select)
      PPGT_CLK_FINE: upper_tick = prescale_tap_fine;
      PPGT_CLK_MID: upper_tick = prescale_tap_mid;
      PPGT_CLK_COARSE: upper_tick = prescale_tap_coarse;
      default: upper_tick = 1'b0;
    endcase
  end

  assign programmable_pulse_mode = (mode_sel == PPGT_MODE_PULSE);
  assign pwm_mode = (mode_sel == PPGT_MODE_PWM);

  // Match and overflow events, all qualified by a lower tick and run bit
  always_comb begin
    lo_match = lower_run_bit
               & cmp_hit(lower_tick, lower_up_counter, lower_compare_reg);
    hi_match = lower_run_bit & programmable_pulse_mode
               & cmp_hit(lower_tick, lower_up_counter, upper_compare_reg);
    ovf_2n = 1'b0;
    if (lower_run_bit && lower_tick && pwm_mode) begin
      unique case (pwm_cycle_select)
        PPGT_CYC_64: ovf_2n = (lower_up_counter[5:0] == 6'h3f);
        PPGT_CYC_128: ovf_2n = (lower_up_counter[6:0] == 7'h7f);
        PPGT_CYC_256: ovf_2n = (lower_up_counter == 8'hff);
        default: ovf_2n = 1'b0;
      endcase
    end
    clear_lower = hi_match | ovf_2n;
    ff_event = ((programmable_pulse_mode
                 & (lo_match | hi_match))
               | (pwm_mode & (lo_match | ovf_2n)))
               & invert_enable;
    lower_next = lower_up_counter + 8'h01;
  end

  // Lower up counter
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      lower_up_counter <= PPGT_CNT_RST;
    end else if (!lower_run_bit) begin
      lower_up_counter <= PPGT_CNT_RST;
    end else if (clear_lower) begin
      lower_up_counter <= PPGT_CNT_RST;
    end else if (lower_tick) begin
      lower_up_counter <= lower_next;
    end
  end

  // Upper timer: free 8-bit interval counter outside programmable pulse mode
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      upper_up_counter <= PPGT_CNT_RST;
    end else if (!upper_run_bit || programmable_pulse_mode) begin
      upper_up_counter <= PPGT_CNT_RST;
    end else if (upper_match) begin
      upper_up_counter <= PPGT_CNT_RST;
    end else if (upper_tick) begin
      upper_up_counter <= upper_up_counter + 8'h01;
    end
  end

  assign upper_match = upper_run_bit & ~programmable_pulse_mode
                       & cmp_hit(upper_tick, upper_up_counter,
                                 upper_compare_reg);

  // Lower compare: written straight with buffering off; with it on, loaded from the buffer only in pulse or pulse-width mode
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      lower_buffer <= PPGT_CMP_RST;
    end else if (lower_cmp_wr) begin
      lower_buffer <= cmp_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      lower_compare_reg <= PPGT_CMP_RST;
    end else if (lower_cmp_wr && !dbuf_enable) begin
      lower_compare_reg <= cmp_wdata;
    end else if (dbuf_enable && programmable_pulse_mode && hi_match) begin
      lower_compare_reg <= lower_buffer;
    end else if (dbuf_enable && pwm_mode && ovf_2n) begin
      lower_compare_reg <= lower_buffer;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      upper_compare_reg <= PPGT_CMP_RST;
    end else if (upper_cmp_wr) begin
      upper_compare_reg <= cmp_wdata;
    end
  end

  // Output flip-flop; a preset write wins over a toggle in the same cycle
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      output_flip_flop <= PPGT_FF_RST;
    end else if (ff_ctrl_wr && ff_ctrl_op == PPGT_FF_SET) begin
      output_flip_flop <= 1'b1;
    end else if (ff_ctrl_wr && ff_ctrl_op == PPGT_FF_CLEAR) begin
      output_flip_flop <= 1'b0;
    end else if (ff_ctrl_wr && ff_ctrl_op == PPGT_FF_INVERT) begin
      output_flip_flop <= ~output_flip_flop;
    end else if (ff_event) begin
      output_flip_flop <= ~output_flip_flop;
    end
  end

  assign timer_output_pin = output_flip_flop;

  // Checks
  a_pulse_toggle: assert property (@(posedge mclk) disable iff (!rstn)
    (programmable_pulse_mode && invert_enable && !ff_ctrl_wr
     && (lo_match || hi_match))
    |=> (timer_output_pin != $past(timer_output_pin)))
    else $error("pulse toggle missing");
  a_pulse_clear: assert property (@(posedge mclk) disable iff (!rstn)
    hi_match |=> (lower_up_counter == 8'h00))
    else $error("pulse counter not cleared");
  a_pwm_clear: assert property (@(posedge mclk) disable iff (!rstn)
    ovf_2n |=> (lower_up_counter == 8'h00))
    else $error("pwm counter not cleared");
  a_pwm_bound: assert property (@(posedge mclk) disable iff (!rstn)
    (pwm_mode && pwm_cycle_select == PPGT_CYC_64 && $stable(mode_sel))
    |-> (lower_up_counter < 8'h40 || $past(lower_up_counter) >= 8'h40))
    else $error("pwm 2^6 period exceeded");
  a_run_stop: assert property (@(posedge mclk) disable iff (!rstn)
    !lower_run_bit |=> (lower_up_counter == 8'h00))
    else $error("stopped counter not zero");
  a_dbuf_pulse: assert property (@(posedge mclk) disable iff (!rstn)
    (dbuf_enable && programmable_pulse_mode && hi_match)
    |=> (lower_compare_reg == $past(lower_buffer)))
    else $error("pulse buffer not loaded");
  a_dbuf_pwm: assert property (@(posedge mclk) disable iff (!rstn)
    (dbuf_enable && pwm_mode && ovf_2n)
    |=> (lower_compare_reg == $past(lower_buffer)))
    else $error("pwm buffer not loaded");
  a_ff_hold: assert property (@(posedge mclk) disable iff (!rstn)
    (!invert_enable && !ff_ctrl_wr) |=> $stable(timer_output_pin))
    else $error("flip-flop moved without inversion");
  a_ff_preset: assert property (@(posedge mclk) disable iff (!rstn)
    (ff_ctrl_wr && ff_ctrl_op == PPGT_FF_CLEAR) |=> !timer_output_pin)
    else $error("clear preset not taken");
  // A 00h period must end on the wrap from ffh: toggle and restart
  a_wrap_00: assert property (@(posedge mclk) disable iff (!rstn)
    (programmable_pulse_mode && invert_enable && !ff_ctrl_wr
     && lower_run_bit && lower_tick && upper_compare_reg == 8'h00
     && lower_up_counter == 8'hff)
    |=> (lower_up_counter == 8'h00
         && timer_output_pin != $past(timer_output_pin)))
    else $error("00h compare missed overflow");

  c_pulse_hi: cover property (@(posedge mclk) disable iff (!rstn)
    programmable_pulse_mode && hi_match);
  c_pwm_ovf: cover property (@(posedge mclk) disable iff (!rstn)
    pwm_mode && ovf_2n);
  c_pwm_lo: cover property (@(posedge mclk) disable iff (!rstn)
    pwm_mode && lo_match);
  c_upper: cover property (@(posedge mclk) disable iff (!rstn) upper_match);
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ppgt_pkg::*;
  logic mclk = 1'b0, rstn = 1'b0, ext_clk_pin = 1'b0, invert_enable = 1'b1;
  logic prescale_tap_fine = 1'b1, prescale_tap_mid = 1'b0;
  logic prescale_tap_coarse = 1'b0, dbuf_enable = 1'b0;
  logic lower_run_bit = 1'b0, upper_run_bit = 1'b0, ff_ctrl_wr = 1'b0;
  logic lower_cmp_wr = 1'b0, upper_cmp_wr = 1'b0;
  ppgt_mode_t mode_sel = PPGT_MODE_PULSE;
  logic [1:0] pwm_cycle_select = 2'h1, lower_clk_select = PPGT_CLK_FINE;
  logic [1:0] upper_clk_select = PPGT_CLK_FINE, ff_ctrl_op = 2'h3;
  logic [7:0] cmp_wdata = 8'h00, gc = 8'h00;
  logic timer_output_pin, upper_match;
  logic [7:0] lower_up_counter, upper_up_counter;
  logic [7:0] lower_compare_reg, upper_compare_reg;
  int err_total = 0, comparisons = 0, tg, hi, mx, um;

  ppgt_timer ppgt_timer_i (.mclk, .rstn, .ext_clk_pin, .prescale_tap_fine,
    .prescale_tap_mid, .prescale_tap_coarse, .lower_run_bit, .upper_run_bit,
    .dbuf_enable, .mode_sel, .pwm_cycle_select, .lower_clk_select,
    .upper_clk_select, .lower_cmp_wr, .upper_cmp_wr, .cmp_wdata, .ff_ctrl_wr,
    .ff_ctrl_op, .invert_enable, .timer_output_pin, .upper_match,
    .lower_up_counter, .upper_up_counter, .lower_compare_reg,
    .upper_compare_reg);

  initial forever #5 mclk = ~mclk;

  // Taps: mid every 4th cycle, coarse every 16th, pin rises every 16th
  always @(negedge mclk) begin
    gc <= gc + 8'h01;
    prescale_tap_mid <= (gc[1:0] == 2'h0);
    prescale_tap_coarse <= (gc[3:0] == 4'h0);
    ext_clk_pin <= gc[3];
  end

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chkn(input int got, input int a, input int b);
    comparisons++;
    if (got < a || got > b) begin
      err_total++;
      $display("Error at %0t: count %0d not in %0d..%0d", $time, got, a, b);
    end
  endtask

  task wr(input logic lo_sel, input logic [7:0] d);
    @(negedge mclk);
    cmp_wdata = d;
    lower_cmp_wr = lo_sel;
    upper_cmp_wr = !lo_sel;
    @(negedge mclk);
    lower_cmp_wr = 1'b0;
    upper_cmp_wr = 1'b0;
  endtask

  task ff(input logic [1:0] op);
    @(negedge mclk);
    ff_ctrl_op = op;
    ff_ctrl_wr = 1'b1;
    @(negedge mclk);
    ff_ctrl_wr = 1'b0;
  endtask

  // Stop first so the compare writes land on an idle counter
  task setup(input ppgt_mode_t m, input logic [7:0] lo, input logic [7:0] up,
             input logic inv);
    @(negedge mclk);
    lower_run_bit = 1'b0;
    upper_run_bit = 1'b0;
    dbuf_enable = 1'b0;
    invert_enable = inv;
    mode_sel = m;
    wr(1'b1, lo);
    wr(1'b0, up);
    ff(PPGT_FF_CLEAR);
    @(negedge mclk);
    lower_run_bit = 1'b1;
    upper_run_bit = 1'b1;
  endtask

  // Counts pin toggles, high cycles, upper matches and the counter peak
  task watch(input int n);
    logic p;
    tg = 0;
    hi = 0;
    mx = 0;
    um = 0;
    p = timer_output_pin;
    repeat (n) begin
      @(negedge mclk);
      tg += (timer_output_pin !== p);
      hi += (timer_output_pin === 1'b1);
      um += (upper_match === 1'b1);
      if (lower_up_counter > mx) mx = lower_up_counter;
      p = timer_output_pin;
    end
  endtask

  // A buffered write must wait for the reload event, which also clears
  task t_dbuf(input logic [7:0] old);
    int k;
    @(negedge mclk);
    dbuf_enable = 1'b1;
    wr(1'b1, 8'h20);
    chk8(lower_compare_reg, old);
    k = 0;
    while (lower_compare_reg !== 8'h20 && k < 600) begin
      @(negedge mclk);
      k++;
    end
    chk8(lower_compare_reg, 8'h20);
    chk8(lower_up_counter, 8'h00);
  endtask

  task t_ffops;
    lower_run_bit = 1'b0;
    ff(PPGT_FF_SET);
    chk8({7'h00, timer_output_pin}, 8'h01);
    ff(PPGT_FF_CLEAR);
    chk8({7'h00, timer_output_pin}, 8'h00);
    ff(PPGT_FF_INVERT);
    chk8({7'h00, timer_output_pin}, 8'h01);
  endtask

  // Upper timer is held in pulse mode, then counts once pulse-width is chosen
  task t_stop;
    chk8(upper_up_counter, 8'h00);
    @(negedge mclk);
    mode_sel = PPGT_MODE_PWM;
    repeat (3) @(negedge mclk);
    chk8(upper_up_counter, 8'h03);
    lower_run_bit = 1'b0;
    upper_run_bit = 1'b0;
    repeat (4) @(negedge mclk);
    chk8(lower_up_counter, 8'h00);
    chk8(upper_up_counter, 8'h00);
  endtask

  // Free count over 64 cycles from each clock source; the upper timer
  // counts the same taps in pulse-width mode, and nothing on code 00
  task t_clk;
    int e, u0, u1;
    wr(1'b0, 8'h00);
    for (int s = 0; s < 4; s++) begin
      @(negedge mclk);
      lower_run_bit = 1'b0;
      upper_run_bit = 1'b0;
      mode_sel = PPGT_MODE_PWM;
      lower_clk_select = 2'(s);
      upper_clk_select = 2'(s);
      e = (s == 0) ? 4 : (64 >> (2 * (s - 1)));
      u0 = (s == 0) ? 0 : e - 1;
      u1 = (s == 0) ? 0 : e + 1;
      @(negedge mclk);
      lower_run_bit = 1'b1;
      upper_run_bit = 1'b1;
      repeat (64) @(negedge mclk);
      chkn(int'(lower_up_counter), e - 1, e + 1);
      chkn(int'(upper_up_counter), u0, u1);
    end
    lower_clk_select = PPGT_CLK_FINE;
  endtask

  task results;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_total++;
    results;
  end

  initial begin
    int p;
    repeat (8) @(negedge mclk);
    chk8(lower_up_counter, 8'h00);
    chk8({7'h00, timer_output_pin}, 8'h00);
    rstn = 1'b1;
    t_ffops;
    setup(PPGT_MODE_PULSE, 8'h01, 8'h04, 1'b1);
    watch(40);
    chkn(tg, 20, 20);
    chkn(mx, 3, 3);
    chkn(hi, 30, 30);
    setup(PPGT_MODE_PULSE, 8'h01, 8'h04, 1'b0);
    watch(40);
    chkn(tg, 0, 0);
    setup(PPGT_MODE_PULSE, 8'h80, 8'h00, 1'b1);
    watch(512);
    chkn(tg, 4, 4);
    chkn(mx, 255, 255);
    for (int c = 1; c < 4; c++) begin
      pwm_cycle_select = 2'(c);
      p = 32 << c;
      setup(PPGT_MODE_PWM, 8'h10, 8'h05, 1'b1);
      watch(2 * p);
      chkn(tg, 4, 4);
      chkn(mx, p - 1, p - 1);
      chkn(hi, 2 * (p - 16), 2 * (p - 16));
      chkn(um, 2 * p / 5, 2 * p / 5 + 1);
    end
    setup(PPGT_MODE_PWM, 8'h10, 8'h05, 1'b1);
    t_dbuf(8'h10);
    setup(PPGT_MODE_PULSE, 8'h10, 8'h40, 1'b1);
    t_dbuf(8'h10);
    t_stop;
    t_clk;
    results;
  end
endmodule
`default_nettype wire
